// File: iom_regs.svh
// Offsets, field positions, reset values and timing counts of the process image block.
`ifndef IOM_REGS_SVH
`define IOM_REGS_SVH
`define IOM_NPORT 4
`define IOM_IMG_BYTES 64
`define IOM_STATUS_OFF 6'h00
`define IOM_DATA_LAST 7'h3f
`define IOM_OBJ_BASE 16'h6000
`define IOM_SUB_FIRST 8'h01
`define IOM_SUB_LAST 8'h3f
`define IOM_ST_ALARM 0
`define IOM_ST_PARAM 1
`define IOM_ST_SETUP 2
`define IOM_ST_RUN 6
`define IOM_ST_HEART 7
`define IOM_STATUS_RST 8'h00
`define IOM_Q_VALID 7
`define IOM_Q_FAULT 6
`define IOM_Q_PRESENT 5
`define IOM_QUAL_RST 8'h00
`define IOM_HB_MIN 14'd1
`define IOM_HB_MAX 14'd10000
`define IOM_HB_DEF 14'd100
`define IOM_CLK_HZ 200000000
`define IOM_TICK_US 100
`define IOM_US_PER_S 1000000
`define IOM_CYC_PER_TICK (`IOM_CLK_HZ / `IOM_US_PER_S * `IOM_TICK_US)
`define IOM_TICKS_PER_MS 4'd10
`define IOM_RETRIES 2'd2
`define IOM_RATE_COM1 2'd1
`define IOM_RATE_COM3 2'd3
`define IOM_FIFO_DEPTH 16
`endif

// File: iom_pkg.sv
// Types shared by the process image block and its helpers.
package iom_pkg;
  typedef enum logic [3:0] {
    st_off = 4'b0001,
    st_startup = 4'b0010,
    st_preop = 4'b0100,
    st_operate = 4'b1000
  } iom_link_state_t;

  typedef struct packed {
    logic attached;
    logic iol_mode;
    logic rate_valid;
    logic [1:0] rate_code;
    logic [7:0] cycle_time;
    logic id_valid;
    logic [31:0] id_value;
    logic dl_done;
    logic tel_ok;
    logic tel_fault;
    logic no_response;
    logic dev_fault;
  } iom_link_in_t;

  typedef struct packed {
    iom_link_state_t state;
    logic [1:0] rate;
    logic dl_req;
    logic cycle_tick;
    logic fault;
    logic abort;
  } iom_link_out_t;

  typedef struct packed {
    logic [5:0] offset;
    logic [5:0] length;
  } iom_map_t;

  typedef struct packed {
    logic [1:0] port;
    logic [4:0] idx;
    logic [7:0] data;
  } iom_in_byte_t;

  typedef struct packed {
    iom_link_out_t link;
    logic [7:0] cyc_cnt;
    logic [1:0] retry;
    logic rate_set;
    logic [7:0] qual_last;
  } iom_port_t;

  typedef struct packed {
    iom_port_t [3:0] port;
    logic [7:0] status;
    logic [31:0] tick_cnt;
    logic [3:0] tenth;
    logic [13:0] ms_cnt;
    logic [1:0] qual_sel;
    logic rd1_valid;
    logic rd1_err;
    logic rd1_status;
    logic rd_valid;
    logic rd_err;
    logic [7:0] rd_data;
  } iom_top_state_t;
endpackage : iom_pkg

// File: iom_fifo.sv
// Valid/ready FIFO for port input bytes on their way into the image.
module iom_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg, wr_next, rd_reg, rd_next, cnt;
  logic full_reg, full_next, empty_reg, empty_next;
  logic push, pop;

  assign push = in_valid && !full_reg;
  assign pop = out_ready && !empty_reg;
  assign in_ready = !full_reg;
  assign out_valid = !empty_reg;
  assign out_data = mem[rd_reg[AW-1:0]];

  always_comb begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    cnt = wr_next - rd_next;
    full_next = (cnt == (AW + 1)'(DEPTH));
    empty_next = (cnt == '0);
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
    if (reset) begin
      wr_reg <= '0;
      rd_reg <= '0;
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      full_reg <= full_next;
      empty_reg <= empty_next;
    end
  end
endmodule : iom_fifo

// File: iom_img_mem.sv
// Byte store of the input image with a registered read port.
module iom_img_mem (
  // Clock.
  input wire logic sys_clk,
  // Write port.
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port, data one cycle after the address.
  input wire logic [5:0] rd_addr,
  output logic [7:0] rd_data_reg
);
  // Contents are not cleared by reset; unmapped bytes read whatever was last stored.
  logic [7:0] mem [64];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_reg <= mem[rd_addr];
  end
endmodule : iom_img_mem

// File: iom_image.sv
// Port link sequencing, heartbeat and 64-byte input image of the master.
`include "iom_regs.svh"

module iom_image
  import iom_pkg::*;
#(
  parameter int CYC_PER_TICK = `IOM_CYC_PER_TICK
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Link side, one entry per port.
  input wire iom_link_in_t [`IOM_NPORT-1:0] link_in,
  input wire logic [`IOM_NPORT-1:0][31:0] cfg_id,
  output iom_link_out_t [`IOM_NPORT-1:0] link_out,
  // Port input bytes from the links.
  input wire logic in_valid,
  output logic in_ready,
  input wire iom_in_byte_t in_byte,
  // Master configuration.
  input wire iom_map_t [`IOM_NPORT-1:0] in_map,
  input wire logic qualifier_append_option,
  input wire logic [13:0] heartbeat_interval_ms,
  // Firmware condition.
  input wire logic fw_init_done,
  input wire logic bootloader_mode,
  input wire logic internal_alarm_flag,
  input wire logic parameter_fault_flag,
  input wire logic setup_fault_in,
  // Head module read port.
  input wire logic rd_req,
  input wire logic rd_by_object,
  input wire logic [5:0] rd_addr,
  input wire logic [15:0] rd_index,
  input wire logic [7:0] rd_subindex,
  input wire logic [7:0] slot,
  output logic rd_valid,
  output logic rd_err,
  output logic [7:0] rd_data,
  // Status byte as a level.
  output logic [7:0] master_status_byte
);
  iom_top_state_t s_reg, s_next;
  iom_in_byte_t fifo_data;
  logic fifo_valid, fifo_ready;
  logic mem_we;
  logic [5:0] mem_waddr, mem_raddr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [13:0] hb_interval;
  logic [7:0] qual;
  logic [6:0] qaddr, daddr;
  logic qual_write, rd_ok, any_fault, tick100;
  iom_map_t m;

  iom_fifo #(.WIDTH($bits(iom_in_byte_t)), .DEPTH(`IOM_FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_byte),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  iom_img_mem u_mem (
    .sys_clk(sys_clk),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(mem_raddr),
    .rd_data_reg(mem_rdata)
  );

  // Out-of-range intervals are clamped rather than refused.
  always_comb begin
    if (heartbeat_interval_ms < `IOM_HB_MIN) begin
      hb_interval = `IOM_HB_MIN;
    end else if (heartbeat_interval_ms > `IOM_HB_MAX) begin
      hb_interval = `IOM_HB_MAX;
    end else begin
      hb_interval = heartbeat_interval_ms;
    end
  end

  // Image write arbitration and read address decode.
  always_comb begin
    m = in_map[s_reg.qual_sel];
    qual = `IOM_QUAL_RST;
    qual[`IOM_Q_VALID] = (s_reg.port[s_reg.qual_sel].link.state == st_operate);
    qual[`IOM_Q_FAULT] = link_in[s_reg.qual_sel].dev_fault;
    qual[`IOM_Q_PRESENT] = (s_reg.port[s_reg.qual_sel].link.state == st_operate)
        || (s_reg.port[s_reg.qual_sel].link.state == st_preop);
    qaddr = {1'b0, m.offset} + {1'b0, m.length};
    // A changed qualifier takes the write port and holds the FIFO for that cycle.
    qual_write = qualifier_append_option && link_in[s_reg.qual_sel].iol_mode
        && (qual != s_reg.port[s_reg.qual_sel].qual_last)
        && (m.offset != `IOM_STATUS_OFF) && (qaddr <= `IOM_DATA_LAST);
    daddr = {1'b0, in_map[fifo_data.port].offset} + {2'b00, fifo_data.idx};
    fifo_ready = !qual_write;
    mem_we = 1'b0;
    mem_waddr = qaddr[5:0];
    mem_wdata = qual;
    if (qual_write) begin
      mem_we = 1'b1;
    end else if (fifo_valid && s_reg.port[fifo_data.port].link.state == st_operate
        && ({1'b0, fifo_data.idx} < in_map[fifo_data.port].length)
        && (in_map[fifo_data.port].offset != `IOM_STATUS_OFF)
        && (daddr <= `IOM_DATA_LAST)) begin
      mem_we = 1'b1;
      mem_waddr = daddr[5:0];
      mem_wdata = fifo_data.data;
    end
    if (rd_by_object) begin
      rd_ok = (rd_index == 16'(`IOM_OBJ_BASE + {8'h00, slot}))
          && (rd_subindex >= `IOM_SUB_FIRST) && (rd_subindex <= `IOM_SUB_LAST);
      mem_raddr = rd_subindex[5:0] - 6'h01;
    end else begin
      rd_ok = 1'b1;
      mem_raddr = rd_addr;
    end
  end

  // Next state of ports, heartbeat, status and read pipeline.
  always_comb begin
    s_next = s_reg;
    any_fault = 1'b0;
    tick100 = (s_reg.tick_cnt == 32'(CYC_PER_TICK - 1));
    s_next.tick_cnt = tick100 ? 32'h0 : s_reg.tick_cnt + 32'h1;
    if (tick100) begin
      s_next.tenth = s_reg.tenth + 4'h1;
      if (s_reg.tenth == `IOM_TICKS_PER_MS - 4'h1) begin
        s_next.tenth = 4'h0;
        if (s_reg.ms_cnt + 14'h1 >= hb_interval) begin
          s_next.ms_cnt = 14'h0;
          s_next.status[`IOM_ST_HEART] = !s_reg.status[`IOM_ST_HEART];
        end else begin
          s_next.ms_cnt = s_reg.ms_cnt + 14'h1;
        end
      end
    end
    for (int i = 0; i < `IOM_NPORT; i++) begin
      s_next.port[i].link.cycle_tick = 1'b0;
      s_next.port[i].link.abort = 1'b0;
      s_next.port[i].link.dl_req = 1'b0;
      if (!(link_in[i].attached && link_in[i].iol_mode)) begin
        s_next.port[i].link.state = st_off;
        s_next.port[i].link.fault = 1'b0;
        s_next.port[i].rate_set = 1'b0;
      end else begin
        case (s_reg.port[i].link.state)
          st_off: begin
            s_next.port[i].link.state = st_startup;
            s_next.port[i].rate_set = 1'b0;
            s_next.port[i].retry = 2'd0;
          end
          st_startup: begin
            if (link_in[i].no_response) begin
              s_next.port[i].link.fault = 1'b1;
            end
            if (!s_reg.port[i].rate_set) begin
              if (link_in[i].rate_valid) begin
                if (link_in[i].rate_code >= `IOM_RATE_COM1
                    && link_in[i].rate_code <= `IOM_RATE_COM3) begin
                  s_next.port[i].rate_set = 1'b1;
                  s_next.port[i].link.rate = link_in[i].rate_code;
                  s_next.port[i].cyc_cnt = 8'h0;
                end else begin
                  s_next.port[i].link.fault = 1'b1;
                end
              end
            end else if (link_in[i].id_valid) begin
              if (link_in[i].id_value == cfg_id[i]) begin
                s_next.port[i].link.state = st_preop;
                s_next.port[i].link.fault = 1'b0;
                s_next.port[i].link.dl_req = 1'b1;
              end else begin
                s_next.port[i].link.fault = 1'b1;
              end
            end
          end
          st_preop: begin
            s_next.port[i].link.dl_req = 1'b1;
            if (link_in[i].dl_done) begin
              s_next.port[i].link.dl_req = 1'b0;
              s_next.port[i].link.state = st_operate;
              s_next.port[i].retry = 2'd0;
              s_next.port[i].cyc_cnt = 8'h0;
            end
          end
          st_operate: begin
            // A zero cycle time is treated as one tick.
            if (tick100) begin
              if (s_reg.port[i].cyc_cnt + 8'h1 >= link_in[i].cycle_time) begin
                s_next.port[i].cyc_cnt = 8'h0;
                s_next.port[i].link.cycle_tick = 1'b1;
              end else begin
                s_next.port[i].cyc_cnt = s_reg.port[i].cyc_cnt + 8'h1;
              end
            end
            if (link_in[i].tel_fault) begin
              if (s_reg.port[i].retry == `IOM_RETRIES) begin
                s_next.port[i].link.abort = 1'b1;
                s_next.port[i].link.fault = 1'b1;
                s_next.port[i].link.state = st_startup;
                s_next.port[i].rate_set = 1'b0;
                s_next.port[i].retry = 2'd0;
              end else begin
                s_next.port[i].retry = s_reg.port[i].retry + 2'd1;
              end
            end else if (link_in[i].tel_ok) begin
              s_next.port[i].retry = 2'd0;
            end
          end
          default: begin
            s_next.port[i].link.state = st_off;
          end
        endcase
      end
      any_fault = any_fault || s_reg.port[i].link.fault;
    end
    if (qual_write) begin
      s_next.port[s_reg.qual_sel].qual_last = qual;
    end
    s_next.qual_sel = s_reg.qual_sel + 2'd1;
    s_next.status[`IOM_ST_ALARM] = internal_alarm_flag;
    s_next.status[`IOM_ST_PARAM] = parameter_fault_flag;
    s_next.status[`IOM_ST_SETUP] = setup_fault_in || any_fault;
    s_next.status[`IOM_ST_RUN] = fw_init_done && !bootloader_mode;
    s_next.status[5:3] = 3'b000;
    s_next.rd1_valid = rd_req;
    s_next.rd1_err = !rd_ok;
    s_next.rd1_status = (mem_raddr == `IOM_STATUS_OFF);
    s_next.rd_valid = s_reg.rd1_valid;
    s_next.rd_err = s_reg.rd1_valid && s_reg.rd1_err;
    if (s_reg.rd1_valid && !s_reg.rd1_err) begin
      s_next.rd_data = s_reg.rd1_status ? s_reg.status : mem_rdata;
    end else begin
      s_next.rd_data = 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_reg <= '0;
      for (int i = 0; i < `IOM_NPORT; i++) begin
        s_reg.port[i].link.state <= st_off;
      end
      s_reg.status <= `IOM_STATUS_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link_out = {s_reg.port[3].link, s_reg.port[2].link,
                     s_reg.port[1].link, s_reg.port[0].link};
  assign rd_valid = s_reg.rd_valid;
  assign rd_err = s_reg.rd_err;
  assign rd_data = s_reg.rd_data;
  assign master_status_byte = s_reg.status;
endmodule : iom_image

// File: iom_image_sva.sv
// Concurrent checks on the ports of the process image block.
module iom_image_sva
  import iom_pkg::*;
#(
  parameter int CYC_PER_TICK = 4
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Link side.
  input wire iom_link_in_t [3:0] link_in,
  input wire logic [3:0][31:0] cfg_id,
  input wire iom_link_out_t [3:0] link_out,
  // Configuration and firmware condition.
  input wire logic [13:0] heartbeat_interval_ms,
  input wire logic fw_init_done,
  input wire logic bootloader_mode,
  input wire logic parameter_fault_flag,
  // Read port and status.
  input wire logic rd_req,
  input wire logic rd_by_object,
  input wire logic [15:0] rd_index,
  input wire logic [7:0] rd_subindex,
  input wire logic [7:0] slot,
  input wire logic rd_valid,
  input wire logic rd_err,
  input wire logic [7:0] master_status_byte
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic obj_bad;
  logic hb_prev_reg;
  logic [31:0] hb_cnt_reg;
  logic [31:0] hb_lim;
  logic [13:0] hb_ms;
  assign obj_bad = rd_index != 16'h6000 + {8'h00, slot} || rd_subindex == 8'h00
    || rd_subindex > 8'h3f;
  assign hb_ms = heartbeat_interval_ms == 14'h0 ? 14'h1 : heartbeat_interval_ms;
  // One extra millisecond of slack covers the phase of the first toggle after reset.
  assign hb_lim = ({18'h0, hb_ms} + 32'h1) * 32'ha * 32'(CYC_PER_TICK);
  always_ff @(posedge sys_clk) begin
    hb_prev_reg <= master_status_byte[7];
    if (reset || master_status_byte[7] != hb_prev_reg) begin
      hb_cnt_reg <= 32'h0;
    end else begin
      hb_cnt_reg <= hb_cnt_reg + 32'h1;
    end
  end
  AST_RD_LAT: assert property (rd_req |-> ##2 rd_valid)
    else $error("read answer not two cycles after request");
  AST_RD_SPUR: assert property (rd_valid |-> $past(rd_req, 2))
    else $error("read answer without request");
  AST_OBJ_ERR: assert property (rd_req |-> ##2 rd_err == $past(rd_by_object && obj_bad, 2))
    else $error("object read error flag wrong");
  AST_RUN: assert property (!$past(reset) |->
    master_status_byte[6] == $past(fw_init_done && !bootloader_mode))
    else $error("running flag wrong");
  AST_FLAGS: assert property (!$past(reset) |->
    master_status_byte[1] == $past(parameter_fault_flag) && master_status_byte[5:3] == 3'h0)
    else $error("parameter flag or reserved bits wrong");
  AST_HB_MIN: assert property ($changed(master_status_byte[7]) |=>
    $stable(master_status_byte[7])[*8])
    else $error("heartbeat toggles too fast");
  AST_HB_MAX: assert property (hb_cnt_reg <= hb_lim)
    else $error("heartbeat stalled");
  AST_START: assert property (link_out[0].state == st_off && link_in[0].attached
    && link_in[0].iol_mode |=> link_out[0].state == st_startup)
    else $error("attached port did not enter startup");
  AST_ID_BAD: assert property (link_out[3].state == st_startup && link_in[3].id_valid
    && link_in[3].id_value != cfg_id[3] |=> link_out[3].state == st_startup && link_out[3].fault)
    else $error("identification mismatch not held in startup");
  AST_PREOP: assert property (link_out[0].state == st_preop |-> link_out[0].dl_req)
    else $error("no parameter download in preoperate");
  AST_ABORT: assert property (link_out[0].abort |->
    ##[0:1] (link_out[0].state == st_startup && link_out[0].fault))
    else $error("abort without fault and startup");
endmodule : iom_image_sva

bind iom_image iom_image_sva #(.CYC_PER_TICK(CYC_PER_TICK)) iom_image_sva_i (.sys_clk(sys_clk),
  .reset(reset), .link_in(link_in), .cfg_id(cfg_id), .link_out(link_out),
  .heartbeat_interval_ms(heartbeat_interval_ms), .fw_init_done(fw_init_done),
  .bootloader_mode(bootloader_mode), .parameter_fault_flag(parameter_fault_flag),
  .rd_req(rd_req), .rd_by_object(rd_by_object), .rd_index(rd_index),
  .rd_subindex(rd_subindex), .slot(slot), .rd_valid(rd_valid), .rd_err(rd_err),
  .master_status_byte(master_status_byte));

// File: iom_dev_model.sv
// Behavioural model of the devices attached to the four ports.
module iom_dev_model
  import iom_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Test control.
  input wire logic [3:0] go,
  input wire logic [3:0] bad_tel,
  input wire logic [3:0][31:0] dev_id,
  // Link side.
  input wire iom_link_out_t [3:0] link_out,
  output iom_link_in_t [3:0] link_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0][1:0] phase;
  logic [3:0][3:0] wait_cnt;
  initial link_in = '0;
  always @(posedge sys_clk) begin
    for (int p = 0; p < 4; p++) begin
      link_in[p] <= '0;
      link_in[p].attached <= go[p];
      link_in[p].iol_mode <= go[p];
      link_in[p].cycle_time <= 8'h01;
      // Fields outside a pulse carry garbage so a stale value is never mistaken for data.
      link_in[p].rate_code <= ~link_in[p].rate_code;
      link_in[p].id_value <= ~link_in[p].id_value;
      wait_cnt[p] <= wait_cnt[p] - 4'h1;
      if (reset || (link_out[p].state != st_startup && link_out[p].state != st_preop)) begin
        phase[p] <= 2'h0;
      end else if (link_out[p].state == st_startup && phase[p] == 2'h0) begin
        link_in[p].rate_valid <= 1'b1;
        link_in[p].rate_code <= 2'(p % 3 + 1);
        phase[p] <= 2'h1;
      end else if (link_out[p].state == st_startup && phase[p] == 2'h1) begin
        link_in[p].id_valid <= 1'b1;
        link_in[p].id_value <= dev_id[p];
        phase[p] <= 2'h2;
        wait_cnt[p] <= 4'(p * 3);
      end else if (link_out[p].dl_req && phase[p] == 2'h2 && wait_cnt[p] == 4'h0) begin
        link_in[p].dl_done <= 1'b1;
        phase[p] <= 2'h3;
      end
      if (link_out[p].cycle_tick) begin
        link_in[p].tel_ok <= !bad_tel[p];
        link_in[p].tel_fault <= bad_tel[p];
      end
    end
  end
endmodule : iom_dev_model

// File: tb_top.sv
// Self-checking testbench of the process image block.
module tb_top;
  import iom_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic err; logic [7:0] data; logic [7:0] mask;} iom_exp_t;
  logic sys_clk, reset, in_valid, in_ready, qualifier_append_option, fw_init_done;
  logic bootloader_mode, internal_alarm_flag, parameter_fault_flag, setup_fault_in;
  logic rd_req, rd_by_object, rd_valid, rd_err;
  logic [5:0] rd_addr;
  logic [15:0] rd_index, oix;
  logic [7:0] rd_subindex, slot, rd_data, master_status_byte;
  logic [13:0] heartbeat_interval_ms;
  logic [3:0] go, bad_tel;
  logic [3:0][31:0] cfg_id, dev_id;
  iom_link_in_t [3:0] link_in;
  iom_link_out_t [3:0] link_out;
  iom_in_byte_t in_byte;
  iom_map_t [3:0] in_map;
  iom_exp_t exp_q[$];
  iom_exp_t cur;
  logic [7:0] img [64];
  logic [31:0] rnd_state = 32'h5e637b7c;
  int n_mismatch = 0;
  int n_tests = 0;
  int n;
  int adr[9] = '{1, 2, 3, 4, 5, 6, 7, 60, 61};
  iom_image #(.CYC_PER_TICK(4)) iom_image_i (.sys_clk(sys_clk), .reset(reset),
    .link_in(link_in), .cfg_id(cfg_id), .link_out(link_out), .in_valid(in_valid),
    .in_ready(in_ready), .in_byte(in_byte), .in_map(in_map),
    .qualifier_append_option(qualifier_append_option),
    .heartbeat_interval_ms(heartbeat_interval_ms), .fw_init_done(fw_init_done),
    .bootloader_mode(bootloader_mode), .internal_alarm_flag(internal_alarm_flag),
    .parameter_fault_flag(parameter_fault_flag), .setup_fault_in(setup_fault_in),
    .rd_req(rd_req), .rd_by_object(rd_by_object), .rd_addr(rd_addr), .rd_index(rd_index),
    .rd_subindex(rd_subindex), .slot(slot), .rd_valid(rd_valid), .rd_err(rd_err),
    .rd_data(rd_data), .master_status_byte(master_status_byte));
  iom_dev_model iom_dev_model_i (.sys_clk(sys_clk), .reset(reset), .go(go),
    .bad_tel(bad_tel), .dev_id(dev_id), .link_out(link_out), .link_in(link_in));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic rd(input logic o, input logic [5:0] a, input logic [15:0] ix,
      input logic [7:0] sx, input logic e, input logic [7:0] d, input logic [7:0] m);
    @(posedge sys_clk);
    rd_req <= 1'b1;
    rd_by_object <= o;
    rd_addr <= a;
    rd_index <= ix;
    rd_subindex <= sx;
    exp_q.push_back('{e, d, m});
    @(posedge sys_clk);
    rd_req <= 1'b0;
  endtask : rd
  task automatic send(input int p, input int i, input logic [7:0] d);
    @(posedge sys_clk);
    in_valid <= 1'b1;
    in_byte <= '{2'(p), 5'(i), d};
    @(negedge sys_clk);
    while (in_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    in_valid <= 1'b0;
  endtask : send
  task automatic wait_state(input int p, input iom_link_state_t s);
    for (int k = 0; k < 400 && link_out[p].state !== s; k++) @(negedge sys_clk);
    check("link state", 32'(link_out[p].state), 32'(s));
  endtask : wait_state
  task automatic hb_span(output int c);
    logic b;
    b = master_status_byte[7];
    for (c = 0; c < 5000 && master_status_byte[7] === b; c++) @(negedge sys_clk);
  endtask : hb_span
  // Read answers are compared in order against the notes left by the read driver.
  always @(negedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      cur = exp_q.pop_front();
      check("read error", 32'(rd_err), 32'(cur.err));
      check("read data", 32'(rd_data & cur.mask), 32'(cur.data & cur.mask));
    end
  end
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {reset, in_valid, rd_req, rd_by_object, go, bad_tel} = {1'b1, 11'h0};
    {qualifier_append_option, bootloader_mode, internal_alarm_flag} = 3'h0;
    {parameter_fault_flag, setup_fault_in, fw_init_done} = 3'h1;
    {rd_addr, rd_index, rd_subindex, slot, in_byte} = '0;
    heartbeat_interval_ms = 14'h1;
    cfg_id = {32'h0bad0004, 32'h0c0de003, 32'h0c0de002, 32'h0c0de001};
    dev_id = {32'h0c0de004, 32'h0c0de003, 32'h0c0de002, 32'h0c0de001};
    in_map = {6'h0a, 6'h02, 6'h3c, 6'h02, 6'h04, 6'h04, 6'h01, 6'h03};
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    for (int k = 0; k < 32; k++) begin
      @(posedge sys_clk);
      {fw_init_done, bootloader_mode, parameter_fault_flag, internal_alarm_flag} <= 4'(k >> 1);
      setup_fault_in <= k[0];
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      check("status", master_status_byte[6:0], {k[4] & !k[3], 3'h0, k[0], k[2], k[1]});
    end
    {fw_init_done, bootloader_mode, parameter_fault_flag, internal_alarm_flag} <= 4'h8;
    setup_fault_in <= 1'b0;
    $display("test status flags done");
    go <= 4'hf;
    for (int p = 0; p < 3; p++) wait_state(p, st_operate);
    wait_state(3, st_startup);
    for (int p = 0; p < 3; p++) check("rate", link_out[p].rate, p % 3 + 1);
    check("port fault", link_out[3].fault, 1);
    $display("test link bring-up done");
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < in_map[p].length; i++) begin
        rnd_state = lfsr_next(rnd_state);
        img[in_map[p].offset + i] = rnd_state[7:0];
        send(p, i, rnd_state[7:0]);
      end
    end
    in_map[0].length <= 6'h02;
    send(0, 2, ~img[3]);
    repeat (30) @(posedge sys_clk);
    rd(1'b0, 6'h00, 16'h0, 8'h0, 1'b0, 8'h44, 8'h7f);
    foreach (adr[j]) rd(1'b0, 6'(adr[j]), 16'h0, 8'h0, 1'b0, img[adr[j]], 8'hff);
    $display("test input image done");
    rnd_state = lfsr_next(rnd_state);
    slot <= rnd_state[7:0];
    @(posedge sys_clk);
    oix = 16'h6000 + {8'h00, slot};
    rd(1'b1, 6'h0, oix, 8'h01, 1'b0, 8'h44, 8'h7f);
    rd(1'b1, 6'h0, oix, 8'h02, 1'b0, img[1], 8'hff);
    rd(1'b1, 6'h0, oix, 8'h3e, 1'b0, img[61], 8'hff);
    // Subindices from 40h upwards and the wrap to zero are all outside the image.
    foreach (adr[j]) rd(1'b1, 6'h0, oix + 16'(j == 0), 8'(j * 24 + 64), 1'b1, 8'h0, 8'hff);
    $display("test object access done");
    qualifier_append_option <= 1'b1;
    repeat (20) @(posedge sys_clk);
    foreach (adr[j]) if (j < 3) rd(1'b0, 6'(j == 0 ? 3 : j == 1 ? 8 : 62), 16'h0, 8'h0, 1'b0, 8'ha0, 8'hff);
    repeat (4) @(posedge sys_clk);
    $display("test qualifier done");
    for (int k = 0; k < 3; k++) begin
      heartbeat_interval_ms <= 14'(k == 2 ? 2 : 1 - k);
      @(negedge sys_clk);
      repeat (3) hb_span(n);
      check("heartbeat period", n, (k == 2 ? 2 : 1) * 40);
    end
    $display("test heartbeat done");
    bad_tel <= 4'h1;
    for (n = 0; n < 400 && link_out[0].abort !== 1'b1; n++) @(negedge sys_clk);
    check("abort", link_out[0].abort, 1);
    @(posedge sys_clk);
    bad_tel <= 4'h0;
    check("state after abort", 32'(link_out[0].state), 32'(st_startup));
    wait_state(0, st_operate);
    $display("test abort done");
    print_verdict();
  end
endmodule : tb_top
